// file: common/eipb_pkg.sv
// Purpose: Constants for the extended interrupt priority block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets and reset values are local choices
package eipb_pkg;
	localparam int          NUM_SRC         = 5;            // Sources covered
	localparam logic [11:0] PRIO_OFFSET     = 12'h000;      // Priority register
	localparam logic [11:0] PENDING_OFFSET  = 12'h004;      // Pending requests, read only
	localparam logic [11:0] ACTIVE_OFFSET   = 12'h008;      // Service level status
	localparam logic [11:0] ACK_OFFSET      = 12'h00C;      // Service acknowledge/return
	localparam logic [7:0]  PRIO_RESET      = 8'h00;        // All low after reset
	localparam logic [7:0]  PRIO_WMASK      = 8'h37;        // Bits 5,4,2,1,0 writable
	localparam int          BIT_CS_CMP      = 5;            // Comparator priority bit
	localparam int          BIT_CS_DONE     = 4;            // Conversion done priority bit
	localparam int          BIT_UNUSED      = 3;            // Unused bit
	localparam int          BIT_RTC_FAIL    = 2;            // Oscillator fail priority bit
	localparam int          BIT_PORT_MATCH  = 1;            // Port match priority bit
	localparam int          BIT_EARLY_WARN  = 0;            // Early warning priority bit
	localparam logic [4:0]  NO_SRC          = 5'h1F;        // Id meaning no request
	localparam logic [3:0]  ACK_ENTER_LOW   = 4'h1;         // Core enters low routine
	localparam logic [3:0]  ACK_ENTER_HIGH  = 4'h2;         // Core enters high routine
	localparam logic [3:0]  ACK_RETURN      = 4'h4;         // Core returns from routine
endpackage : eipb_pkg

// file: rtl/eipb_arbiter.sv
// Purpose: Pick one pending request at each priority level, high and low apart
// Assumes: Requests and priority bits are synchronous to pclk
// Notes:   Lowest source index wins within a level
`timescale 1ns/1ps
`default_nettype none
module eipb_arbiter #(
	parameter int N = 5
) (
	input  wire logic [N-1:0] req,
	input  wire logic [N-1:0] prio,
	output logic              hit_high,
	output logic              hit_low,
	output logic [4:0]        sel_high,
	output logic [4:0]        sel_low
);
	// Ids are five bits wide and the all-ones id means none
	if (N < 1 || N > 31) begin : g_bad_n
		$error("eipb_arbiter serves one to thirty-one sources");
	end

	// Fixed-order search; highest index first so lowest index wins
	always_comb begin
		hit_high = 1'b0;
		hit_low  = 1'b0;
		sel_high = eipb_pkg::NO_SRC;
		sel_low  = eipb_pkg::NO_SRC;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && prio[i]) begin
				hit_high = 1'b1;
				sel_high = 5'(i);
			end
			if (req[i] && !prio[i]) begin
				hit_low = 1'b1;
				sel_low = 5'(i);
			end
		end
	end
endmodule : eipb_arbiter
`default_nettype wire

// file: rtl/eipb_top.sv
// Purpose: Priority-select register for five extended interrupt sources
// Assumes: Core acknowledges entry and return through the ack register
// Notes:   Pending inputs come from flag logic on the same clock
//
// Notes on behaviour
// - Bit five sets comparator priority level
// - Bit four sets conversion done priority
// - Bit three reads zero, writes ignored
// - Bit two sets oscillator fail priority
// - Bit one sets port match priority
// - Bit zero sets early warning priority
`timescale 1ns/1ps
`default_nettype none
module eipb_top #(
	parameter int NUM_SRC = eipb_pkg::NUM_SRC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capsense_comparator_req,
	input  wire logic        capsense_conv_done_req,
	input  wire logic        rtc_osc_fail_req,
	input  wire logic        port_match_req,
	input  wire logic        supply_early_warn_req,
	output logic             core_irq_valid,
	output logic             core_irq_high,
	output logic [4:0]       core_irq_src,
	output logic [7:0]       prio_levels
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	// The request vector below is wired for exactly five named inputs
	if (NUM_SRC != eipb_pkg::NUM_SRC) begin : g_bad_num
		$error("eipb_top serves exactly five sources");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]         prio;          // Priority register
	logic               in_low;        // Core runs a low routine
	logic               in_high;       // Core runs a high routine
	logic [NUM_SRC-1:0] req;           // Pending requests, source order
	logic [NUM_SRC-1:0] prio_vec;      // Priority bit per source
	logic               hit_high;      // Some high request pending
	logic               hit_low;       // Some low request pending
	logic [4:0]         sel_high;      // Chosen high source
	logic [4:0]         sel_low;       // Chosen low source
	logic               setup_ok;      // Access phase of any transfer
	logic               wr_en;         // Write takes effect
	logic               addr_ok;       // Address maps to a register
	logic [31:0]        next_rdata;    // Read mux output
	logic [7:0]         next_prio;     // Masked write value
	logic               next_valid;    // Request to present
	logic               next_high;     // Level of presented request
	logic [4:0]         next_src;      // Id of presented request

	// Source index 0..4 is comparator, done, osc fail, port match, warn
	assign req = {supply_early_warn_req, port_match_req, rtc_osc_fail_req,
		capsense_conv_done_req, capsense_comparator_req};
	assign prio_vec = {prio[eipb_pkg::BIT_EARLY_WARN],
		prio[eipb_pkg::BIT_PORT_MATCH],
		prio[eipb_pkg::BIT_RTC_FAIL],
		prio[eipb_pkg::BIT_CS_DONE],
		prio[eipb_pkg::BIT_CS_CMP]};

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup_ok = psel && penable;
	assign wr_en    = setup_ok && pwrite && addr_ok;

	// Only the defined words answer without error
	always_comb begin
		if (paddr == eipb_pkg::PRIO_OFFSET) begin
			addr_ok = 1'b1;
		end else if (paddr == eipb_pkg::PENDING_OFFSET) begin
			addr_ok = !pwrite;
		end else if (paddr == eipb_pkg::ACTIVE_OFFSET) begin
			addr_ok = !pwrite;
		end else if (paddr == eipb_pkg::ACK_OFFSET) begin
			addr_ok = pwrite;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Reads have no side effects, so a master may repeat one safely
	// The pending word shows raw request levels, not the presented one
	// Read mux; unused bit three and upper bits read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (paddr == eipb_pkg::PRIO_OFFSET) begin
			next_rdata[7:0] = prio & eipb_pkg::PRIO_WMASK;
		end else if (paddr == eipb_pkg::PENDING_OFFSET) begin
			next_rdata[NUM_SRC-1:0] = req;
		end else if (paddr == eipb_pkg::ACTIVE_OFFSET) begin
			next_rdata[1:0] = {in_high, in_low};
		end
	end

	// Byte lane 0 carries the whole register; write mask drops bit three
	assign next_prio = (pwdata[7:0] & eipb_pkg::PRIO_WMASK);

	// Trade-off: ready is a flop rather than a constant, so read data and
	// the error flag are captured at setup and stand steady through access
	// Zero-wait slave: ready answers in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= !addr_ok;
			end
		end
	end

	// ----------------------------------------------------------------
	// Priority register
	// ----------------------------------------------------------------
	// A refused or strobe-less write leaves the register untouched;
	// bit three is masked off on the way in, so it can never read one
	// Write lands at the access edge when pready is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio <= eipb_pkg::PRIO_RESET;
		end else if (wr_en && pready && pstrb[0] &&
			paddr == eipb_pkg::PRIO_OFFSET) begin
			prio <= next_prio;
		end
	end

	// ----------------------------------------------------------------
	// Service level tracking
	// ----------------------------------------------------------------
	// Limitation: one high level nested inside one low level is all that
	// is tracked; entry codes other than the three defined are ignored,
	// and a return with neither level open does nothing
	// Core reports entry and return; a return closes the higher level first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_low  <= 1'b0;
			in_high <= 1'b0;
		end else if (wr_en && pready && paddr == eipb_pkg::ACK_OFFSET) begin
			if (pwdata[3:0] == eipb_pkg::ACK_ENTER_HIGH) begin
				in_high <= 1'b1;
			end else if (pwdata[3:0] == eipb_pkg::ACK_ENTER_LOW) begin
				in_low <= 1'b1;
			end else if (pwdata[3:0] == eipb_pkg::ACK_RETURN) begin
				if (in_high) begin
					in_high <= 1'b0;
				end else begin
					in_low <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	eipb_arbiter #(
		.N (NUM_SRC)
	) u_arb (
		.req      (req),
		.prio     (prio_vec),
		.hit_high (hit_high),
		.hit_low  (hit_low),
		.sel_high (sel_high),
		.sel_low  (sel_low)
	);

	// The arbiter itself is combinational; the choice is registered below
	// so that every output towards the core comes straight from a flop
	// High beats low; high may preempt a low routine, nothing preempts high
	always_comb begin
		next_valid = 1'b0;
		next_high  = 1'b0;
		next_src   = eipb_pkg::NO_SRC;
		if (hit_high && !in_high) begin
			next_valid = 1'b1;
			next_high  = 1'b1;
			next_src   = sel_high;
		end else if (hit_low && !in_high && !in_low) begin
			next_valid = 1'b1;
			next_src   = sel_low;
		end
	end

	// The priority copy trails the register by one cycle, the same lag as
	// the presented request, so both describe the same moment to a watcher
	// Registered request to the core, one cycle behind the inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_irq_valid <= 1'b0;
			core_irq_high  <= 1'b0;
			core_irq_src   <= eipb_pkg::NO_SRC;
			prio_levels    <= eipb_pkg::PRIO_RESET;
		end else begin
			core_irq_valid <= next_valid;
			core_irq_high  <= next_high;
			core_irq_src   <= next_src;
			prio_levels    <= prio & eipb_pkg::PRIO_WMASK;
		end
	end
endmodule : eipb_top
`default_nettype wire

// file: verification/eipb_props.sv
// Purpose: Port checks for the extended interrupt priority block
// Assumes: One pclk domain, async active-low reset
// Notes:   Level checks wait for priorities to sit still
`timescale 1ns/1ps
`default_nettype none
module eipb_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capsense_comparator_req,
	input wire logic        capsense_conv_done_req,
	input wire logic        rtc_osc_fail_req,
	input wire logic        port_match_req,
	input wire logic        supply_early_warn_req,
	input wire logic        core_irq_valid,
	input wire logic        core_irq_high,
	input wire logic [4:0]  core_irq_src,
	input wire logic [7:0]  prio_levels
);
	// ----------------------------------------------------------------
	// Helpers; reqv and hm in source id order
	// ----------------------------------------------------------------
	wire logic [4:0] reqv = {supply_early_warn_req, port_match_req, rtc_osc_fail_req,
		capsense_conv_done_req, capsense_comparator_req};
	wire logic [4:0] hm = {prio_levels[0], prio_levels[1], prio_levels[2], prio_levels[4],
		prio_levels[5]};
	wire logic       acc = psel && penable && pready;
	// The priority copy lands one edge after the access edge of a write and is sampled at the second
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	unused_bit_a: assert property (!prio_levels[3]) else $error("bit 3 set");
	prio_write_a: assert property (acc && pwrite && paddr == 12'h000 && pstrb[0] |->
		##2 prio_levels == ($past(pwdata[7:0], 2) & eipb_pkg::PRIO_WMASK)) else $error("bad write");
	prio_hold_a: assert property (!(acc && pwrite) |-> ##2 $stable(prio_levels))
		else $error("priority moved");
	ready_next_a: assert property (psel && !penable |=> pready) else $error("no ready");
	unmapped_err_a: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
		else $error("no error");
	level_match_a: assert property (core_irq_valid && hm == $past(hm) && hm == $past(hm, 2)
		|-> core_irq_high == hm[core_irq_src]) else $error("wrong level");
	high_first_a: assert property (core_irq_valid && !core_irq_high && hm == $past(hm) &&
		hm == $past(hm, 2) |-> ($past(reqv) & hm) == 5'h00) else $error("low before high");
	src_pending_a: assert property (core_irq_valid |->
		(($past(reqv) >> core_irq_src) & 5'h01) == 5'h01) else $error("source not pending");
	idle_src_a: assert property (!core_irq_valid |-> core_irq_src == eipb_pkg::NO_SRC)
		else $error("idle id");
endmodule : eipb_props
`default_nettype wire

// file: verification/eipb_core_model.sv
// Purpose: Core side that notes each new presentation
// Assumes: Presentation outputs are registered on pclk
// Notes:   A repeat of the same request is not a new one
`timescale 1ns/1ps
`default_nettype none
module eipb_core_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       core_irq_valid,
	input  wire logic       core_irq_high,
	input  wire logic [4:0] core_irq_src,
	output logic            took,
	output logic [5:0]      taken
);
	logic [5:0] last; // Level and id seen last edge
	logic       was;  // Valid seen last edge
	// Vectoring happens on a rise or on a change of request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{was, last, took, taken} <= 14'h0000;
		end else begin
			was <= core_irq_valid;
			last <= {core_irq_high, core_irq_src};
			took <= core_irq_valid && (!was || last != {core_irq_high, core_irq_src});
			taken <= {core_irq_high, core_irq_src};
		end
	end
endmodule : eipb_core_model
`default_nettype wire

// file: verification/eipb_tb.sv
// Purpose: Self-checking bench for the priority block
// Assumes: The bench acks entry and return through the bus
// Notes:   Reads and presentations are checked off queues
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module eipb_tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, v, h, took;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, wd;
	logic [3:0]  pstrb = 4'h0;
	logic [4:0]  req = 5'h00, src;
	logic [5:0]  taken, ie;
	logic [7:0]  pl;
	logic [32:0] re;
	logic [32:0] rq[$];
	logic [5:0]  iq[$];
	int          n_errors = 0, cmp_count = 0;
	int          bt[5] = '{5, 4, 2, 1, 0}; // Priority bit of each source id
	always #10 pclk = ~pclk;
	eipb_top eipb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capsense_comparator_req(req[0]),
		.capsense_conv_done_req(req[1]), .rtc_osc_fail_req(req[2]), .port_match_req(req[3]),
		.supply_early_warn_req(req[4]), .core_irq_valid(v), .core_irq_high(h),
		.core_irq_src(src), .prio_levels(pl));
	eipb_core_model eipb_core_model_i (.pclk(pclk), .presetn(presetn), .core_irq_valid(v),
		.core_irq_high(h), .core_irq_src(src), .took(took), .taken(taken));
	// One APB transfer; a read notes its expected {error, data}
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'hF};
		if (!w) rq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic settle;
		repeat (4) @(posedge pclk);
	endtask : settle
	task automatic report_and_stop;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// Read results; data of a refused read is not meaningful
	always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
		re = rq.pop_front();
		`CHK({pslverr, pslverr ? 32'h0 : prdata}, re)
	end
	// Each new presentation against the oldest note
	always @(posedge pclk) if (took) begin
		ie = iq.pop_front();
		`CHK(taken, ie)
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		void'($urandom(12));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 33'h0);
		apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
		apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
		for (int i = 0; i < 6; i++) begin
			wd = $urandom;
			apb(1'b1, 12'h000, wd, 33'h0);
			apb(1'b0, 12'h000, 32'h0, {25'h0, wd[7:0] & 8'h37});
		end
		// Each source alone at high level, all pending
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h000, 32'h1 << bt[i], 33'h0);
			iq.push_back({1'b1, 5'(i)});
			req <= 5'h1F;
			settle();
			apb(1'b1, 12'h00C, 32'h2, 33'h0);
			req <= 5'h00;
			settle();
			apb(1'b1, 12'h00C, 32'h4, 33'h0);
		end
		// All low: lowest id, then a high one preempts the low routine
		apb(1'b1, 12'h000, 32'h0, 33'h0);
		iq.push_back(6'h00);
		req <= 5'h1F;
		settle();
		apb(1'b1, 12'h00C, 32'h1, 33'h0);
		apb(1'b0, 12'h008, 32'h0, 33'h1);
		iq.push_back(6'h24);
		apb(1'b1, 12'h000, 32'h1, 33'h0);
		settle();
		apb(1'b1, 12'h00C, 32'h2, 33'h0);
		apb(1'b0, 12'h004, 32'h0, 33'h1F);
		apb(1'b0, 12'h008, 32'h0, 33'h3);
		req <= 5'h00;
		settle();
		// Reset in mid-run: priorities and service levels return to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 33'h0);
		apb(1'b0, 12'h008, 32'h0, 33'h0);
		apb(1'b1, 12'h00C, 32'h4, 33'h0);
		apb(1'b1, 12'h00C, 32'h4, 33'h0);
		settle();
		`CHK(rq.size() + iq.size(), 0)
		report_and_stop();
	end
endmodule : eipb_tb
bind eipb_top eipb_props eipb_props_i (.*);
`default_nettype wire
